// ==== verilog/mpc_pkg.sv ====
// Constants, register map and field layout of the multi-channel PWM core.
package mpc_pkg;

   // ****************************************
   // Widths and channel counts.
   // ****************************************
   localparam int ADDR_W = 8;
   localparam int DATA_W = 8;
   localparam int CNT_W = 16;
   localparam int NUM_CH = 8;
   localparam int NUM_PAIR = 4;
   localparam int PRE_W = 3;
   localparam int DEAD_W = 8;

   // ****************************************
   // Register offsets.
   // ****************************************
   localparam logic [ADDR_W-1:0] ADDR_INVERT = 8'hD1;
   localparam logic [ADDR_W-1:0] ADDR_CONTROL = 8'hD2;
   localparam logic [ADDR_W-1:0] ADDR_OUT_EN = 8'hD3;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD_LO = 8'hD4;
   localparam logic [ADDR_W-1:0] ADDR_PERIOD_HI = 8'hD5;
   localparam logic [ADDR_W-1:0] ADDR_DEAD = 8'hD6;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_MASK = 8'hD8;
   localparam logic [ADDR_W-1:0] ADDR_IRQ_STATUS = 8'hD9;
   localparam logic [ADDR_W-1:0] ADDR_DUTY_BASE = 8'hE0;
   localparam logic [ADDR_W-1:0] ADDR_DUTY_LAST = 8'hEF;

   // ****************************************
   // Field positions of the main control register and the interrupt status register.
   // ****************************************
   localparam int CTRL_RUN_BIT = 7;
   localparam int CTRL_FLAG_BIT = 6;
   localparam int CTRL_CLK_HI = 5;
   localparam int CTRL_CLK_LO = 4;
   localparam int CTRL_COMPL_BIT = 1;
   localparam int CTRL_CENTER_BIT = 0;
   localparam logic [DATA_W-1:0] CTRL_WRITE_MASK = 8'hB3;
   localparam int STAT_OVF_BIT = 0;

   // ****************************************
   // Reset values and unit steps.
   // ****************************************
   localparam logic [DATA_W-1:0] REG8_RESET = 8'h00;
   localparam logic [CNT_W-1:0] REG16_RESET = 16'h0000;
   localparam logic [CNT_W:0] CNT_ZERO = 17'h00000;
   localparam logic [CNT_W:0] CNT_ONE = 17'h00001;
   localparam logic [PRE_W-1:0] PRE_ONE = 3'h1;
   localparam logic [DEAD_W-1:0] DEAD_ONE = 8'h01;

endpackage

// ==== verilog/mpc_pwm_core.sv ====
// Eight-channel PWM core with shared counter, register port and interrupt.
`timescale 1ns/100ps
`default_nettype none
// Contract
// R1: Independent mode: common period, per-channel duty.
// R2: Complementary mode: four pairs with dead zone.
// R3: Edge type counts up from zero, match toggles.
// R4: Edge count reaching period plus one clears.
// R5: Edge period is period plus one ticks.
// R6: Center type reverses at period plus one.
// R7: Center toggles both ways, underflow ends period.
// R8: Center period is twice period plus one.
// R9: Run bit set: clock gated in, counting.
// R10: Run bit clear: halt, clear counter, GPIO.
// R11: Overflow sets flag; interrupt only if enabled.
// R12: Flag cleared only by software write.
// R13: Clock select divides oscillator by 1/2/4/8.
// R14: Mode field: complementary bit, center bit.
// R15: Channel output enable selects PWM or GPIO.
// R16: Channel invert bit inverts the waveform.
// R17: Outputs disabled: still counts, still interrupts.
// R18: Sixteen-bit counter, period, duty; even/odd pairs.
// R19: Reserved control bits 3:2 ignored.
module mpc_pwm_core (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [mpc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [mpc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [mpc_pkg::DATA_W-1:0] reg_rdata,
   output logic [mpc_pkg::NUM_CH-1:0] pwm_out,
   output logic [mpc_pkg::NUM_CH-1:0] pwm_oe,
   output logic irq
);
   import mpc_pkg::*;

   // ****************************************
   // Declarations.
   // ****************************************
   logic module_run_q;
   logic overflow_flag_q;
   logic [1:0] clock_prescale_sel_q;
   logic [1:0] mode_align_sel_q;
   logic [NUM_CH-1:0] channel_invert_q;
   logic [NUM_CH-1:0] channel_output_enable_q;
   logic [CNT_W-1:0] shared_period_value_q;
   logic [CNT_W-1:0] period_act_q;
   logic [DEAD_W-1:0] dead_value_q;
   logic [DATA_W-1:0] irq_mask_q;
   logic [DATA_W-1:0] irq_status_q;
   logic [CNT_W-1:0] channel_duty_value_q [NUM_CH];
   logic [CNT_W-1:0] duty_act_q [NUM_CH];
   logic [PRE_W-1:0] pre_cnt_q;
   logic [CNT_W:0] cnt_q;
   logic count_down_q;
   logic [NUM_CH-1:0] base_wave;
   logic [NUM_CH-1:0] raw_wave;
   logic [DEAD_W-1:0] dead_cnt_q [NUM_PAIR];
   logic [NUM_PAIR-1:0] pair_level_q;
   logic [DATA_W-1:0] rd_mux;
   logic tick;
   logic period_end;
   logic reload;
   logic ctrl_wr;
   logic status_rd;
   logic center_mode;
   logic compl_mode;
   logic [CNT_W:0] period_top;

   // ****************************************
   // Helper functions.
   // ****************************************

   // Mask of low prescaler bits that must all be one for a tick.
   function automatic logic [PRE_W-1:0] pre_mask(input logic [1:0] sel);
      logic [PRE_W-1:0] m;
      m = '0;
      for (int i = 0; i < PRE_W; i++) begin
         if (i < int'(sel)) begin
            m[i] = 1'b1;
         end
      end
      return m;
   endfunction

   // True when the address falls inside the duty window for a channel.
   function automatic logic duty_hit(input logic [ADDR_W-1:0] a, input int ch,
                                     input logic hi);
      return a == ADDR_W'(int'(ADDR_DUTY_BASE) + 2 * ch + int'(hi));
   endfunction

   // ****************************************
   // Decode of mode and bus strobes.
   // ****************************************

   // R14 mode decode
   assign compl_mode = mode_align_sel_q[CTRL_COMPL_BIT];
   assign center_mode = mode_align_sel_q[CTRL_CENTER_BIT];
   assign ctrl_wr = reg_wr && (reg_addr == ADDR_CONTROL);
   assign status_rd = reg_rd && (reg_addr == ADDR_IRQ_STATUS);
   assign period_top = {1'b0, period_act_q} + CNT_ONE;

   // R13 prescale enable pulse
   assign tick = module_run_q && ((pre_cnt_q & pre_mask(clock_prescale_sel_q))
                                  == pre_mask(clock_prescale_sel_q));

   // ****************************************
   // Control register.
   // ****************************************

   // Run, prescale and mode fields; reserved bits are dropped.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         module_run_q <= 1'b0;
         clock_prescale_sel_q <= 2'h0;
         mode_align_sel_q <= 2'h0;
      end else if (ctrl_wr) begin
         // R19 reserved ignored
         module_run_q <= reg_wdata[CTRL_RUN_BIT];
         clock_prescale_sel_q <= reg_wdata[CTRL_CLK_HI:CTRL_CLK_LO];
         mode_align_sel_q <= reg_wdata[CTRL_COMPL_BIT:CTRL_CENTER_BIT];
      end
   end

   // Overflow flag: hardware sets, a written zero clears, the set wins.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         overflow_flag_q <= 1'b0;
      end else if (period_end) begin
         // R11 flag set
         overflow_flag_q <= 1'b1;
      end else if (ctrl_wr && !reg_wdata[CTRL_FLAG_BIT]) begin
         // R12 software clear
         overflow_flag_q <= 1'b0;
      end
   end

   // ****************************************
   // Other software registers.
   // ****************************************

   // Channel, period, dead zone and mask registers.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         channel_invert_q <= REG8_RESET;
         channel_output_enable_q <= REG8_RESET;
         shared_period_value_q <= REG16_RESET;
         dead_value_q <= REG8_RESET;
         irq_mask_q <= REG8_RESET;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_INVERT) begin
            channel_invert_q <= reg_wdata;
         end else if (reg_addr == ADDR_OUT_EN) begin
            channel_output_enable_q <= reg_wdata;
         end else if (reg_addr == ADDR_PERIOD_LO) begin
            shared_period_value_q[DATA_W-1:0] <= reg_wdata;
         end else if (reg_addr == ADDR_PERIOD_HI) begin
            shared_period_value_q[CNT_W-1:DATA_W] <= reg_wdata;
         end else if (reg_addr == ADDR_DEAD) begin
            dead_value_q <= reg_wdata;
         end else if (reg_addr == ADDR_IRQ_MASK) begin
            irq_mask_q <= reg_wdata;
         end
      end
   end

   // Per-channel duty registers and their active copies.
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_duty
         // R1 per-channel duty
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               channel_duty_value_q[c] <= REG16_RESET;
            end else if (reg_wr && duty_hit(reg_addr, c, 1'b0)) begin
               channel_duty_value_q[c][DATA_W-1:0] <= reg_wdata;
            end else if (reg_wr && duty_hit(reg_addr, c, 1'b1)) begin
               channel_duty_value_q[c][CNT_W-1:DATA_W] <= reg_wdata;
            end
         end

         // A new duty takes effect at the next period boundary.
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               duty_act_q[c] <= REG16_RESET;
            end else if (reload) begin
               duty_act_q[c] <= channel_duty_value_q[c];
            end
         end
      end
   endgenerate

   // Active period follows the same boundary so a cycle is never cut short.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         period_act_q <= REG16_RESET;
      end else if (reload) begin
         period_act_q <= shared_period_value_q;
      end
   end

   // ****************************************
   // Prescaler and shared counter.
   // ****************************************

   // Free divider of the oscillator clock, held at zero while stopped.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pre_cnt_q <= '0;
      end else if (!module_run_q) begin
         pre_cnt_q <= '0;
      end else begin
         pre_cnt_q <= pre_cnt_q + PRE_ONE;
      end
   end

   // End of a PWM period in either alignment.
   always_comb begin
      period_end = 1'b0;
      if (tick) begin
         if (!center_mode) begin
            // R4 edge overflow
            period_end = (cnt_q == {1'b0, period_act_q});
         end else if (count_down_q) begin
            // R7 underflow ends period
            period_end = (cnt_q == CNT_ONE);
         end else begin
            period_end = (cnt_q == period_top) && (period_act_q == REG16_RESET);
         end
      end
   end

   assign reload = period_end || !module_run_q;

   // Up counter for edge type, up then down for center type.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q <= CNT_ZERO;
         count_down_q <= 1'b0;
      end else if (!module_run_q) begin
         // R10 halt and clear
         cnt_q <= CNT_ZERO;
         count_down_q <= 1'b0;
      end else if (period_end) begin
         // R5 edge period length
         cnt_q <= CNT_ZERO;
         count_down_q <= 1'b0;
      end else if (tick) begin
         // R9 counting while running
         if (center_mode && !count_down_q && cnt_q == period_top) begin
            // R6 reverse at midpoint
            cnt_q <= {1'b0, period_act_q};
            count_down_q <= 1'b1;
         end else if (center_mode && count_down_q) begin
            // R8 down leg completes period
            cnt_q <= cnt_q - CNT_ONE;
         end else begin
            // R3 upward count
            cnt_q <= cnt_q + CNT_ONE;
            count_down_q <= 1'b0;
         end
      end
   end

   // ****************************************
   // Channel waveforms.
   // ****************************************

   // Compare the shared count with each duty; the down leg includes the match.
   generate
      for (genvar c = 0; c < NUM_CH; c++) begin : g_cmp
         // R3 duty match toggles
         // R7 match on both legs
         assign base_wave[c] = count_down_q ? (cnt_q <= {1'b0, duty_act_q[c]})
                                            : (cnt_q < {1'b0, duty_act_q[c]});
      end
   endgenerate

   // Complementary pairs: even duty drives both, each turn-on edge delayed by dead zone.
   generate
      for (genvar p = 0; p < NUM_PAIR; p++) begin : g_pair
         // R2 dead zone insertion
         always_ff @(posedge ref_clk or negedge reset_n) begin
            if (!reset_n) begin
               pair_level_q[p] <= 1'b0;
               dead_cnt_q[p] <= REG8_RESET;
            end else if (base_wave[2*p] != pair_level_q[p]) begin
               pair_level_q[p] <= base_wave[2*p];
               dead_cnt_q[p] <= dead_value_q;
            end else if (dead_cnt_q[p] != REG8_RESET) begin
               dead_cnt_q[p] <= dead_cnt_q[p] - DEAD_ONE;
            end
         end

         // R18 even/odd pairing
         always_comb begin
            if (compl_mode) begin
               raw_wave[2*p] = pair_level_q[p] && (dead_cnt_q[p] == REG8_RESET)
                               && (base_wave[2*p] == pair_level_q[p]);
               raw_wave[2*p+1] = !pair_level_q[p] && (dead_cnt_q[p] == REG8_RESET)
                                 && (base_wave[2*p] == pair_level_q[p]);
            end else begin
               raw_wave[2*p] = base_wave[2*p];
               raw_wave[2*p+1] = base_wave[2*p+1];
            end
         end
      end
   endgenerate

   // Pins: PWM with inversion when enabled and running, otherwise GPIO.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         pwm_out <= '0;
         pwm_oe <= '0;
      end else if (!module_run_q) begin
         // R10 pins return to GPIO
         pwm_out <= '0;
         pwm_oe <= '0;
      end else begin
         // R16 inversion
         pwm_out <= (raw_wave ^ channel_invert_q) & channel_output_enable_q;
         // R15 output enable
         pwm_oe <= channel_output_enable_q;
      end
   end

   // ****************************************
   // Interrupt.
   // ****************************************

   // Sticky status, cleared by a read of it; a new event wins over the clear.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq_status_q <= REG8_RESET;
      end else if (period_end) begin
         // R17 timer still interrupts
         irq_status_q[STAT_OVF_BIT] <= 1'b1;
      end else if (status_rd) begin
         irq_status_q <= REG8_RESET;
      end
   end

   // Level interrupt while any unmasked status bit is set.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         irq <= 1'b0;
      end else begin
         // R11 gated by enable
         irq <= |(irq_status_q & irq_mask_q);
      end
   end

   // ****************************************
   // Read port.
   // ****************************************

   // Read multiplexer; unmapped addresses return zero.
   always_comb begin
      rd_mux = REG8_RESET;
      if (reg_addr == ADDR_CONTROL) begin
         rd_mux[CTRL_RUN_BIT] = module_run_q;
         rd_mux[CTRL_FLAG_BIT] = overflow_flag_q;
         rd_mux[CTRL_CLK_HI:CTRL_CLK_LO] = clock_prescale_sel_q;
         rd_mux[CTRL_COMPL_BIT:CTRL_CENTER_BIT] = mode_align_sel_q;
      end else if (reg_addr == ADDR_INVERT) begin
         rd_mux = channel_invert_q;
      end else if (reg_addr == ADDR_OUT_EN) begin
         rd_mux = channel_output_enable_q;
      end else if (reg_addr == ADDR_PERIOD_LO) begin
         rd_mux = shared_period_value_q[DATA_W-1:0];
      end else if (reg_addr == ADDR_PERIOD_HI) begin
         rd_mux = shared_period_value_q[CNT_W-1:DATA_W];
      end else if (reg_addr == ADDR_DEAD) begin
         rd_mux = dead_value_q;
      end else if (reg_addr == ADDR_IRQ_MASK) begin
         rd_mux = irq_mask_q;
      end else if (reg_addr == ADDR_IRQ_STATUS) begin
         rd_mux = irq_status_q;
      end else if (reg_addr >= ADDR_DUTY_BASE && reg_addr <= ADDR_DUTY_LAST) begin
         for (int c = 0; c < NUM_CH; c++) begin
            if (duty_hit(reg_addr, c, 1'b0)) begin
               rd_mux = channel_duty_value_q[c][DATA_W-1:0];
            end else if (duty_hit(reg_addr, c, 1'b1)) begin
               rd_mux = channel_duty_value_q[c][CNT_W-1:DATA_W];
            end
         end
      end
   end

   // Read data stands for the one cycle after the strobe.
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         reg_rdata <= REG8_RESET;
      end else if (reg_rd) begin
         reg_rdata <= rd_mux;
      end else begin
         reg_rdata <= REG8_RESET;
      end
   end

endmodule
`default_nettype wire

// ==== tb/mpc_pwm_core_asserts.sv ====
// Port-level concurrent checks for the multi-channel PWM core.
`timescale 1ns/100ps
`default_nettype none
module mpc_core_chk (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic [mpc_pkg::ADDR_W-1:0] reg_addr,
   input wire logic [mpc_pkg::DATA_W-1:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [mpc_pkg::DATA_W-1:0] reg_rdata,
   input wire logic [mpc_pkg::NUM_CH-1:0] pwm_out,
   input wire logic [mpc_pkg::NUM_CH-1:0] pwm_oe,
   input wire logic irq
);
   import mpc_pkg::*;
   logic [DATA_W-1:0] ctrl_q, en_q, inv_q;
   logic mask_q;
   logic rd_stat;
   logic compl_on;
   // ****************************************
   // Shadow copies of what software wrote.
   // ****************************************
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         ctrl_q <= 8'h00;
         en_q <= 8'h00;
         inv_q <= 8'h00;
         mask_q <= 1'b0;
      end else if (reg_wr) begin
         if (reg_addr == ADDR_CONTROL) ctrl_q <= reg_wdata & CTRL_WRITE_MASK;
         if (reg_addr == ADDR_OUT_EN) en_q <= reg_wdata;
         if (reg_addr == ADDR_INVERT) inv_q <= reg_wdata;
         if (reg_addr == ADDR_IRQ_MASK) mask_q <= reg_wdata[0];
      end
   end
   // Decoded conditions used by the properties below.
   assign rd_stat = reg_rd && reg_addr == ADDR_IRQ_STATUS;
   assign compl_on = ctrl_q[CTRL_RUN_BIT] && ctrl_q[CTRL_COMPL_BIT] && inv_q == 8'h00;
   // ****************************************
   // Properties.
   // ****************************************
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);
   sequence s_ctrl_read;
      reg_rd && reg_addr == ADDR_CONTROL;
   endsequence
   sequence s_flag_read;
      irq && rd_stat && !$past(rd_stat);
   endsequence
   a_oe_follow: assert property (pwm_oe == ($past(ctrl_q[7]) ? $past(en_q) : 8'h00))
      else $error("pin enables differ from run and channel enables");
   a_out_stop: assert property (!$past(ctrl_q[7]) |-> pwm_out == 8'h00)
      else $error("waveform seen while module stopped");
   a_out_gated: assert property ((pwm_out & ~pwm_oe) == 8'h00)
      else $error("waveform on a disabled channel");
   a_irq_masked: assert property (!$past(mask_q) |-> !irq)
      else $error("interrupt raised while disabled");
   a_irq_sticky: assert property (irq && mask_q && !$past(rd_stat) |=> irq)
      else $error("interrupt dropped without a status read");
   a_stat_reads: assert property (s_flag_read |=> reg_rdata[STAT_OVF_BIT])
      else $error("status read lost the overflow event");
   a_ctrl_readback: assert property (s_ctrl_read |=> (reg_rdata & 8'hBF) == $past(ctrl_q))
      else $error("control readback differs from written fields");
   a_compl_pair: assert property ($past(compl_on, 2) && $past(compl_on) && compl_on
      |-> (pwm_out & (pwm_out >> 1) & 8'h55) == 8'h00)
      else $error("both outputs of a pair high");
endmodule
`default_nettype wire

// ==== tb/tb.sv ====
// Self-checking bench for the multi-channel PWM core.
`timescale 1ns/100ps
`default_nettype none
module tb;
   import mpc_pkg::*;
   logic ref_clk, reset_n, reg_wr, reg_rd, irq;
   logic [ADDR_W-1:0] reg_addr;
   logic [DATA_W-1:0] reg_wdata, reg_rdata;
   logic [NUM_CH-1:0] pwm_out, pwm_oe;
   int error_cnt, compares;
   int hi_cnt[NUM_CH];
   logic [CNT_W-1:0] duty[NUM_CH];

   mpc_pwm_core i_dut (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .reg_addr(reg_addr),
      .reg_wdata(reg_wdata),
      .reg_wr(reg_wr),
      .reg_rd(reg_rd),
      .reg_rdata(reg_rdata),
      .pwm_out(pwm_out),
      .pwm_oe(pwm_oe),
      .irq(irq)
   );

   // Free-running 125 MHz clock.
   initial begin
      ref_clk = 1'b0;
      forever #4 ref_clk = ~ref_clk;
   end

   // ****************************************
   // Bus, compare and measuring tasks.
   // ****************************************
   task automatic print_verdict();
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask

   task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge ref_clk);
      reg_wr <= 1'b1;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge ref_clk);
      reg_wr <= 1'b0;
   endtask

   task automatic wr16(input logic [7:0] a, input logic [15:0] v);
      wr(a, v[7:0]);
      wr(a + 8'h01, v[15:8]);
   endtask

   // Read data is taken in the one cycle where it stands.
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(posedge ref_clk);
      reg_rd <= 1'b1;
      reg_addr <= a;
      @(posedge ref_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask

   // Counts high cycles of every channel over a window.
   task automatic measure(input int win);
      foreach (hi_cnt[i]) hi_cnt[i] = 0;
      repeat (win) begin
         @(posedge ref_clk);
         #1;
         foreach (hi_cnt[i]) hi_cnt[i] += int'(pwm_out[i] === 1'b1);
      end
   endtask

   // Readback value expected after a write of d to address a.
   function automatic logic [7:0] rb_exp(input logic [7:0] a, input logic [7:0] d);
      if (a == ADDR_CONTROL) return d & CTRL_WRITE_MASK;
      if ((a >= ADDR_INVERT && a <= ADDR_DEAD) || a == ADDR_IRQ_MASK) return d;
      if (a >= ADDR_DUTY_BASE && a <= ADDR_DUTY_LAST) return d;
      return 8'h00;
   endfunction

   // Watchdog cuts a hang short.
   initial begin
      repeat (30000) @(posedge ref_clk);
      error_cnt++;
      print_verdict();
   end

   // ****************************************
   // Main sequence.
   // ****************************************
   initial begin
      logic [7:0] d, inv, oe, ctl;
      int p, div, win, ex;
      reset_n = 1'b0;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
      error_cnt = 0;
      compares = 0;
      void'($urandom(32'h21D0));
      repeat (10) @(posedge ref_clk);
      reset_n <= 1'b1;
      // Reset values, readback and unmapped places across the map.
      for (int a = 8'hD0; a <= 8'hF0; a++) begin
         rd(8'(a), d);
         chk("reset", d, 16'h0000);
         d = 8'($urandom);
         if (a == ADDR_CONTROL) d &= 8'h7F;
         if (a == ADDR_IRQ_MASK) d &= 8'h01;
         wr(8'(a), d);
         rd(8'(a), ctl);
         chk("readback", ctl, rb_exp(8'(a), d));
      end
      for (int m = 0; m < 8; m++) begin
         p = $urandom_range(5, 2);
         div = 1 << (m % 4);
         inv = 8'($urandom);
         oe = 8'($urandom);
         wr(ADDR_CONTROL, 8'h00);
         wr16(ADDR_PERIOD_LO, 16'(p));
         for (int c = 0; c < NUM_CH; c++) begin
            duty[c] = 16'($urandom_range(p, 0));
            wr16(8'(ADDR_DUTY_BASE + 2 * c), duty[c]);
         end
         wr(ADDR_INVERT, inv);
         wr(ADDR_OUT_EN, oe);
         ctl = 8'h80 | 8'((m % 4) << 4) | 8'(m / 4) | (8'($urandom) & 8'h0C);
         wr(ADDR_CONTROL, ctl);
         win = (p + 1) * div * (1 + m / 4);
         repeat (3 * win) @(posedge ref_clk);
         measure(2 * win);
         for (int c = 0; c < NUM_CH; c++) begin
            ex = 2 * int'(duty[c]) * div * (1 + m / 4);
            if (inv[c]) ex = 2 * win - ex;
            if (!oe[c]) ex = 0;
            chk("high_cycles", 16'(hi_cnt[c]), 16'(ex));
         end
      end
      // overflow flag and interrupt with all pins off.
      wr(ADDR_CONTROL, 8'h00);
      wr(ADDR_OUT_EN, 8'h00);
      wr16(ADDR_PERIOD_LO, 16'h0003);
      wr(ADDR_IRQ_MASK, 8'h01);
      rd(ADDR_IRQ_STATUS, d);
      wr(ADDR_CONTROL, 8'h80);
      repeat (12) @(posedge ref_clk);
      // Let the edge's register updates settle before looking at the pin.
      #1;
      chk("irq_on", 16'(irq), 16'h0001);
      rd(ADDR_CONTROL, d);
      chk("flag_set", d, 16'h00C0);
      wr(ADDR_CONTROL, 8'h40);
      rd(ADDR_IRQ_STATUS, d);
      chk("status", d, 16'h0001);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("irq_cleared", 16'(irq), 16'h0000);
      rd(ADDR_CONTROL, d);
      chk("flag_kept", d, 16'h0040);
      wr(ADDR_CONTROL, 8'h00);
      rd(ADDR_CONTROL, d);
      chk("flag_clear", d, 16'h0000);
      wr(ADDR_IRQ_MASK, 8'h00);
      wr(ADDR_CONTROL, 8'h80);
      repeat (12) @(posedge ref_clk);
      #1;
      chk("irq_masked", 16'(irq), 16'h0000);
      rd(ADDR_CONTROL, d);
      chk("flag_unmasked", d, 16'h00C0);
      // complementary pairs with a dead zone, both alignments.
      wr(ADDR_CONTROL, 8'h00);
      wr16(ADDR_PERIOD_LO, 16'h0009);
      wr(ADDR_DEAD, 8'h02);
      wr(ADDR_INVERT, 8'h00);
      wr(ADDR_OUT_EN, 8'hFF);
      for (int c = 0; c < NUM_CH; c += 2) wr16(8'(ADDR_DUTY_BASE + 2 * c), 16'h0005);
      for (int m = 2; m < 4; m++) begin
         wr(ADDR_CONTROL, 8'h00);
         wr(ADDR_CONTROL, 8'h80 | 8'(m));
         win = 10 * (m - 1);
         repeat (3 * win) @(posedge ref_clk);
         measure(win);
         for (int c = 0; c < NUM_CH; c += 2) begin
            ex = 5 * (m - 1);
            chk("pair", 16'(hi_cnt[c] > 0 && hi_cnt[c] < ex && hi_cnt[c + 1] > 0
               && hi_cnt[c + 1] < ex), 16'h0001);
         end
      end
      // stopping returns every pin to general I/O.
      wr(ADDR_CONTROL, 8'h00);
      repeat (3) @(posedge ref_clk);
      #1;
      chk("stopped", {pwm_oe, pwm_out}, 16'h0000);
      print_verdict();
   end
endmodule

bind mpc_pwm_core mpc_core_chk i_chk (
   .ref_clk(ref_clk),
   .reset_n(reset_n),
   .reg_addr(reg_addr),
   .reg_wdata(reg_wdata),
   .reg_wr(reg_wr),
   .reg_rd(reg_rd),
   .reg_rdata(reg_rdata),
   .pwm_out(pwm_out),
   .pwm_oe(pwm_oe),
   .irq(irq)
);
`default_nettype wire
